// ==== logic/clp_converter.sv ====
// Palette converter: lookup table, pixel pipeline and host access engine.
// Assumes all logic runs on the pixel clock; host requests arrive by toggle handshake.
//
// Contract
// - Table holds 256 entries of 18 bits
// - Pixel index selects the displayed table entry
// - Entry splits into red, green, blue fields
// - Pixel mask modifies index before lookup
// - Eight-bit host port, synchronized to pixel clock
// - Inputs sampled, visible three edges later
// - Blanking low forces red, green, blue outputs zero
// - Border low selects border color register
// - Shutdown low holds all outputs zero
// - Outputs invalid several cycles after shutdown release
// - Host writes start location to write address
// - Host writes red, green, blue in order
// - Third byte stores entry, then increments address
// - Read address load prefetches entry, increments
// - Three reads; blue read prefetches next entry
// - New address discards partial three-byte sequence
`timescale 1ns/1ps
module clp_converter
  import clp_pkg::*;
(
  // Link to host controller
  clp_link_if.device LINK,
  // Video inputs, pixel clock domain
  input  wire logic                  SRST,
  input  wire logic [CLP_IDX_W-1:0]  PIXEL_INDEX,
  input  wire logic                  BLANK_N,
  input  wire logic                  BORDER_N,
  input  wire logic                  CONVERTER_SHUTDOWN_N,
  input  wire logic [CLP_WORD_W-1:0] BORDER_COLOR,
  // Converter outputs
  output logic [CLP_COMP_W-1:0]      RED,
  output logic [CLP_COMP_W-1:0]      GREEN,
  output logic [CLP_COMP_W-1:0]      BLUE,
  output logic                       OUT_VALID
);
  logic [CLP_WORD_W-1:0] table_mem [CLP_ENTRIES];
  logic [CLP_IDX_W-1:0]  pix_mask;
  logic [CLP_IDX_W-1:0]  s1_idx;
  logic                  s1_blank_n;
  logic                  s1_border_n;
  logic [CLP_WORD_W-1:0] s2_word;
  logic                  s2_blank_n;
  logic                  s2_border_n;
  logic [CLP_WORD_W-1:0] s3_word;
  logic                  s3_blank_n;
  logic                  s3_border_n;
  logic [CLP_IDX_W-1:0]  addr;
  logic [1:0]            comp;
  logic [CLP_WORD_W-1:0] value;
  logic [2:0]            req_sync;
  logic                  req_seen;
  logic [3:0]            wake_cnt;
  logic                  ack_tgl;
  logic [7:0]            ack_data;
  logic                  req_evt;
  logic [1:0]            rst_sync;
  logic                  rst;

  // Blue byte closes a three-byte sequence
  function automatic logic last_comp(input logic [1:0] c);
    return c == 2'h2;
  endfunction

  assign LINK.ack_tgl  = ack_tgl;
  assign LINK.ack_data = ack_data;

  // --------------------------------------------------------------
  // Reset crossing
  // --------------------------------------------------------------
  // Reset is launched on the host clock; two flops keep it off a pixel edge
  always_ff @(posedge LINK.pix_clk) begin
    rst_sync <= {rst_sync[0], SRST};
  end
  assign rst = rst_sync[1];

  // --------------------------------------------------------------
  // Video pipeline
  // --------------------------------------------------------------
  always_ff @(posedge LINK.pix_clk) begin
    s1_idx      <= PIXEL_INDEX;
    s1_blank_n  <= BLANK_N;
    s1_border_n <= BORDER_N;
    s2_word     <= table_mem[s1_idx & pix_mask];
    s2_blank_n  <= s1_blank_n;
    s2_border_n <= s1_border_n;
    // Alignment stage so the output register is the third edge after capture
    s3_word     <= s2_word;
    s3_blank_n  <= s2_blank_n;
    s3_border_n <= s2_border_n;
  end

  always_ff @(posedge LINK.pix_clk) begin
    if (rst || !CONVERTER_SHUTDOWN_N) begin
      {RED, GREEN, BLUE} <= '0;
    end else if (!s3_blank_n) begin
      {RED, GREEN, BLUE} <= '0;
    end else if (!s3_border_n) begin
      {RED, GREEN, BLUE} <= BORDER_COLOR;
    end else begin
      {RED, GREEN, BLUE} <= s3_word;
    end
  end

  // Settling after shutdown release; display must ignore output until valid
  always_ff @(posedge LINK.pix_clk) begin
    if (rst || !CONVERTER_SHUTDOWN_N) begin
      wake_cnt  <= '0;
      OUT_VALID <= 1'b0;
    end else if (wake_cnt != 4'(CLP_WAKE_CYCLES)) begin
      wake_cnt  <= wake_cnt + 4'h1;
      OUT_VALID <= 1'b0;
    end else begin
      OUT_VALID <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Host access engine
  // --------------------------------------------------------------
  always_ff @(posedge LINK.pix_clk) begin
    if (rst) begin
      req_sync <= '0;
      req_seen <= 1'b0;
    end else begin
      req_sync <= {req_sync[1:0], LINK.req_tgl};
      req_seen <= req_sync[2];
    end
  end
  // Request fields are stable while the toggle is in flight
  assign req_evt = req_sync[2] != req_seen;

  always_ff @(posedge LINK.pix_clk) begin
    if (rst) begin
      addr     <= '0;
      comp     <= '0;
      value    <= '0;
      pix_mask <= CLP_MASK_RESET;
      ack_tgl  <= 1'b0;
      ack_data <= '0;
    end else if (req_evt) begin
      ack_tgl  <= ~ack_tgl;
      ack_data <= '0;
      if (LINK.req_wr) begin
        case (LINK.req_sel)
          CLP_SEL_WADDR: begin
            addr <= LINK.req_data;
            comp <= '0;
          end
          CLP_SEL_RADDR: begin
            value <= table_mem[LINK.req_data];
            addr  <= LINK.req_data + 8'h01;
            comp  <= '0;
          end
          CLP_SEL_VALUE: begin
            case (comp)
              2'h0: value[17:12] <= LINK.req_data[5:0];
              2'h1: value[11:6]  <= LINK.req_data[5:0];
              default: value[5:0] <= LINK.req_data[5:0];
            endcase
            if (last_comp(comp)) begin
              comp <= '0;
              addr <= addr + 8'h01;
            end else begin
              comp <= comp + 2'h1;
            end
          end
          default: pix_mask <= LINK.req_data;
        endcase
      end else begin
        case (LINK.req_sel)
          CLP_SEL_VALUE: begin
            case (comp)
              2'h0: ack_data <= {2'h0, value[17:12]};
              2'h1: ack_data <= {2'h0, value[11:6]};
              default: ack_data <= {2'h0, value[5:0]};
            endcase
            if (last_comp(comp)) begin
              comp  <= '0;
              value <= table_mem[addr];
              addr  <= addr + 8'h01;
            end else begin
              comp <= comp + 2'h1;
            end
          end
          CLP_SEL_MASK: ack_data <= pix_mask;
          default:      ack_data <= addr;
        endcase
      end
    end
  end

  // Table write on the third component, at the address before increment
  always_ff @(posedge LINK.pix_clk) begin
    if (!rst && req_evt && LINK.req_wr && LINK.req_sel == CLP_SEL_VALUE && last_comp(comp)) begin
      table_mem[addr] <= {value[17:6], LINK.req_data[5:0]};
    end
  end
endmodule

// ==== logic/clp_pkg.sv ====
// Package for the palette converter path: constants, host register codes, reset values.
// Assumes both ends compile it first.
package clp_pkg;
  localparam int CLP_ENTRIES     = 256;
  localparam int CLP_IDX_W       = 8;
  localparam int CLP_COMP_W      = 6;
  localparam int CLP_WORD_W      = 18;
  localparam int CLP_PIPE_STAGES = 3;
  localparam int CLP_WAKE_CYCLES = 8;
  // Host register selects on the device port
  localparam logic [1:0] CLP_SEL_WADDR = 2'h0;
  localparam logic [1:0] CLP_SEL_RADDR = 2'h1;
  localparam logic [1:0] CLP_SEL_VALUE = 2'h2;
  localparam logic [1:0] CLP_SEL_MASK  = 2'h3;
  // Controller software register offsets
  localparam logic [3:0] CLP_OFS_CMD    = 4'h0;
  localparam logic [3:0] CLP_OFS_WDATA  = 4'h1;
  localparam logic [3:0] CLP_OFS_STATUS = 4'h2;
  localparam logic [3:0] CLP_OFS_RDATA  = 4'h3;
  localparam logic [3:0] CLP_OFS_BORDER = 4'h4;
  localparam logic [3:0] CLP_OFS_VIDEO  = 4'h5;
  localparam logic [7:0]  CLP_MASK_RESET   = 8'hff;
  localparam logic [17:0] CLP_BORDER_RESET = 18'h00000;
  localparam logic [2:0]  CLP_VIDEO_RESET  = 3'h7;
endpackage

// ==== logic/clp_link_if.sv ====
// Interface joining the host-side controller and the palette converter.
// Assumes the bench supplies pix_clk to both ends.
`timescale 1ns/1ps
interface clp_link_if;
  logic       pix_clk;
  logic       req_tgl;
  logic       req_wr;
  logic [1:0] req_sel;
  logic [7:0] req_data;
  logic       ack_tgl;
  logic [7:0] ack_data;
  modport device (input pix_clk, req_tgl, req_wr, req_sel, req_data, output ack_tgl, ack_data);
  modport host   (input pix_clk, ack_tgl, ack_data, output req_tgl, req_wr, req_sel, req_data);
endinterface

// ==== logic/clp_host.sv ====
// Host-side controller: software registers on MCLK, toggle handshake to the converter.
// Assumes the converter answers every request once; one request in flight at a time.
`timescale 1ns/1ps
module clp_host
  import clp_pkg::*;
(
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       SRST,
  // Software port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic [7:0]      RDATA,
  // Video controls held for the display side
  output logic [17:0]     BORDER_COLOR,
  output logic [2:0]      VIDEO_CTRL,
  // Link to converter
  clp_link_if.host        LINK
);
  typedef enum logic [0:0] {
    CLP_IDLE = 1'b0,
    CLP_WAIT = 1'b1
  } clp_state_e;

  clp_state_e state;
  logic       req_tgl;
  logic       req_wr;
  logic [1:0] req_sel;
  logic [7:0] req_data;
  logic [7:0] ack_data;
  logic [2:0] ack_sync;
  logic       ack_seen;
  logic [7:0] rx_data;
  logic       ack_evt;
  logic       go;

  assign LINK.req_tgl  = req_tgl;
  assign LINK.req_wr   = req_wr;
  assign LINK.req_sel  = req_sel;
  assign LINK.req_data = req_data;
  assign ack_evt = ack_sync[2] != ack_seen;
  // CMD: bit 2 = write, bits 1:0 = select; launches with WDATA register contents
  assign go = WR && ADDR == CLP_OFS_CMD && state == CLP_IDLE;

  // --------------------------------------------------------------
  // Crossing from the pixel clock
  // --------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ack_sync <= '0;
      ack_seen <= 1'b0;
      ack_data <= '0;
    end else begin
      ack_sync <= {ack_sync[1:0], LINK.ack_tgl};
      ack_seen <= ack_sync[2];
      ack_data <= LINK.ack_data;
    end
  end

  // --------------------------------------------------------------
  // Request engine
  // --------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state    <= CLP_IDLE;
      req_tgl  <= 1'b0;
      req_wr   <= 1'b0;
      req_sel  <= '0;
      rx_data  <= '0;
    end else begin
      case (state)
        CLP_IDLE: if (go) begin
          req_wr  <= WDATA[2];
          req_sel <= WDATA[1:0];
          req_tgl <= ~req_tgl;
          state   <= CLP_WAIT;
        end
        CLP_WAIT: if (ack_evt) begin
          // Data was stable long before the toggle landed, sampled one stage late
          rx_data <= ack_data;
          state   <= CLP_IDLE;
        end
        default: state <= CLP_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      req_data     <= '0;
      BORDER_COLOR <= CLP_BORDER_RESET;
      VIDEO_CTRL   <= CLP_VIDEO_RESET;
    end else if (WR) begin
      case (ADDR)
        CLP_OFS_WDATA: if (state == CLP_IDLE) req_data <= WDATA;
        CLP_OFS_BORDER: BORDER_COLOR <= {BORDER_COLOR[11:0], WDATA[5:0]};
        CLP_OFS_VIDEO:  VIDEO_CTRL <= WDATA[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        CLP_OFS_STATUS: RDATA <= {7'h00, state == CLP_WAIT};
        CLP_OFS_RDATA:  RDATA <= rx_data;
        CLP_OFS_WDATA:  RDATA <= req_data;
        CLP_OFS_VIDEO:  RDATA <= {5'h00, VIDEO_CTRL};
        default:        RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end
endmodule

// ==== tb/clp_link_properties.sv ====
// Checker for the link handshake and the video outputs, all on the pixel clock.
// Assumes the bench instantiates it beside the link and feeds the converter's video pins.
`timescale 1ns/1ps
module clp_link_properties
  import clp_pkg::*;
(
  // Pixel clock domain
  input wire logic                  pix_clk,
  input wire logic                  SRST,
  // Link
  input wire logic                  req_tgl,
  input wire logic                  req_wr,
  input wire logic [1:0]            req_sel,
  input wire logic [7:0]            req_data,
  input wire logic                  ack_tgl,
  input wire logic [7:0]            ack_data,
  // Video
  input wire logic                  BLANK_N,
  input wire logic                  BORDER_N,
  input wire logic                  CONVERTER_SHUTDOWN_N,
  input wire logic [CLP_WORD_W-1:0] BORDER_COLOR,
  input wire logic [CLP_COMP_W-1:0] RED,
  input wire logic [CLP_COMP_W-1:0] GREEN,
  input wire logic [CLP_COMP_W-1:0] BLUE,
  input wire logic                  OUT_VALID
);
  default clocking cb @(posedge pix_clk); endclocking
  default disable iff (SRST);
  // -------------------------------------------------------------
  // Link handshake
  // -------------------------------------------------------------
  a_ack_follows_req: assert property ($changed(req_tgl) |-> ##[2:12] $changed(ack_tgl))
    else $error("link answer missing");
  a_ack_needs_req: assert property ($changed(ack_tgl) |-> $past(req_tgl) != $past(ack_tgl))
    else $error("answer without request");
  a_one_pending: assert property ($changed(req_tgl) |-> $past(req_tgl) == $past(ack_tgl))
    else $error("second request while one pending");
  a_req_fields_hold: assert property ((req_tgl != ack_tgl) && $stable(req_tgl)
    |-> $stable({req_wr, req_sel, req_data}))
    else $error("request fields moved while pending");
  // -------------------------------------------------------------
  // Video path
  // -------------------------------------------------------------
  // Two-cycle windows keep these exact whether the input is seen at either of the two edges
  a_blank_zero: assert property (!BLANK_N [*2] |-> ##3 {RED, GREEN, BLUE} == 18'h00000)
    else $error("blank not zero");
  a_border_path: assert property ((!BORDER_N && BLANK_N && OUT_VALID) [*2] |->
    ##3 {RED, GREEN, BLUE} == BORDER_COLOR)
    else $error("border color not shown");
  a_shutdown_zero: assert property (!CONVERTER_SHUTDOWN_N [*2] |->
    {RED, GREEN, BLUE} == 18'h00000 && !OUT_VALID)
    else $error("outputs live in shutdown");
  a_wake_delay: assert property ($rose(CONVERTER_SHUTDOWN_N) |->
    ##1 !OUT_VALID [*3] ##[3:8] OUT_VALID)
    else $error("wake delay wrong");
endmodule

// ==== tb/color_lookup_dac_path_tb.sv ====
// Testbench for the palette converter path: host controller and converter joined by the link.
// Assumes the package and design files compile first; VIDEO_CTRL bits feed blank, border, shutdown.
`timescale 1ns/1ps
module color_lookup_dac_path_tb;
  import clp_pkg::*;
  logic        mclk, srst, wr, rd, rd_d, out_valid, vchk;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, pix, pn, mask, st, bv;
  logic [17:0] border, bmdl;
  logic [2:0]  vctl;
  logic [5:0]  red, green, blue;
  logic [17:0] mdl [256];
  logic [8:0]  rq [$];
  logic [17:0] vq [$];
  int          error_cnt, num_checks;
  clp_link_if link();
  clp_host u_clp_host (.MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .BORDER_COLOR(border), .VIDEO_CTRL(vctl), .LINK(link));
  clp_converter u_clp_converter (.LINK(link), .SRST(srst), .PIXEL_INDEX(pix), .BLANK_N(vctl[0]),
    .BORDER_N(vctl[1]), .CONVERTER_SHUTDOWN_N(vctl[2]), .BORDER_COLOR(border), .RED(red),
    .GREEN(green), .BLUE(blue), .OUT_VALID(out_valid));
  clp_link_properties u_props (.pix_clk(link.pix_clk), .SRST(srst), .req_tgl(link.req_tgl),
    .req_wr(link.req_wr), .req_sel(link.req_sel), .req_data(link.req_data), .ack_tgl(link.ack_tgl),
    .ack_data(link.ack_data), .BLANK_N(vctl[0]), .BORDER_N(vctl[1]), .CONVERTER_SHUTDOWN_N(vctl[2]),
    .BORDER_COLOR(border), .RED(red), .GREEN(green), .BLUE(blue), .OUT_VALID(out_valid));
  // -------------------------------------------------------------
  // Clocks and watchdog
  // -------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Odd offset keeps the link clock out of phase with the host clock
  initial begin
    link.pix_clk = 1'b0;
    #1.3;
    forever #3 link.pix_clk = ~link.pix_clk;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end
  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string what, logic [17:0] exp, logic [17:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Note bit 8 set means the read result is compared
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d, logic [8:0] note);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) rq.push_back(note);
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic lnk(logic w, logic [1:0] s, logic [7:0] d);
    bus(1'b1, CLP_OFS_WDATA, d, 9'h000);
    bus(1'b1, CLP_OFS_CMD, {5'h00, w, s}, 9'h000);
    st = 8'h01;
    for (int i = 0; i < 60 && st[0] !== 1'b0; i++) begin
      bus(1'b0, CLP_OFS_STATUS, 8'h00, 9'h000);
      @(posedge mclk);
      st = rdata;
    end
    chk("busy", 18'h00000, {17'h00000, st[0]});
  endtask
  task automatic lread(logic [1:0] s, logic [7:0] exp);
    lnk(1'b0, s, 8'h00);
    bus(1'b0, CLP_OFS_RDATA, 8'h00, {1'b1, exp});
  endtask
  task automatic wset(logic [7:0] a, int n);
    logic [17:0] c;
    lnk(1'b1, CLP_SEL_WADDR, a);
    for (int i = 0; i < n; i++) begin
      c = 18'($urandom);
      mdl[8'(a + i)] = c;
      for (int k = 2; k >= 0; k--) lnk(1'b1, CLP_SEL_VALUE, {2'h0, c[k*6 +: 6]});
    end
  endtask
  task automatic rset(logic [7:0] a, int n);
    lnk(1'b1, CLP_SEL_RADDR, a);
    for (int i = 0; i < n; i++)
      for (int k = 2; k >= 0; k--) lread(CLP_SEL_VALUE, {2'h0, mdl[8'(a + i)][k*6 +: 6]});
  endtask
  // -------------------------------------------------------------
  // Monitors and pixel driver
  // -------------------------------------------------------------
  always @(posedge mclk) begin
    rd_d <= rd;
    if (rd_d && rq[0][8]) chk("rdata", {10'h000, rq[0][7:0]}, {10'h000, rdata});
    if (rd_d) rq.delete(0);
  end
  always @(posedge link.pix_clk) begin
    pn = 8'($urandom);
    pix <= pn;
    if (vchk) vq.push_back(mdl[pn & mask]);
  end
  always @(negedge link.pix_clk) begin
    if (vq.size() >= 5) begin
      chk("video", vq[0], {red, green, blue});
      vq.delete(0);
    end
  end
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    {srst, wr, rd, vchk} = 4'h8;
    {addr, wdata} = '0;
    mask = 8'hff;
    error_cnt = 0;
    num_checks = 0;
    void'($urandom(32'h8833));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    bus(1'b0, CLP_OFS_VIDEO, 8'h00, 9'h107);
    lread(CLP_SEL_MASK, CLP_MASK_RESET);
    $display("test reset done");
    wset(8'h00, 16);
    wset(8'hfe, 2);
    lread(CLP_SEL_WADDR, 8'h00);
    lnk(1'b1, CLP_SEL_WADDR, 8'h10);
    lnk(1'b1, CLP_SEL_VALUE, 8'h3f);
    wset(8'h10, 1);
    $display("test table write done");
    rset(8'hfe, 3);
    lnk(1'b1, CLP_SEL_RADDR, 8'h10);
    lread(CLP_SEL_VALUE, {2'h0, mdl[8'h10][17:12]});
    rset(8'h0f, 2);
    $display("test table read done");
    mask = 8'h0f;
    lnk(1'b1, CLP_SEL_MASK, mask);
    for (int k = 0; k < 3; k++) begin
      bv = 8'($urandom) & 8'h3f;
      bmdl = {bmdl[11:0], bv[5:0]};
      bus(1'b1, CLP_OFS_BORDER, bv, 9'h000);
    end
    vchk <= 1'b1;
    repeat (120) @(posedge mclk);
    vchk <= 1'b0;
    repeat (4) @(posedge mclk);
    $display("test pixel lookup done");
    for (int v = 0; v < 8; v++) begin
      bus(1'b1, CLP_OFS_VIDEO, 8'(v), 9'h000);
      repeat (40) @(posedge mclk);
      bus(1'b0, CLP_OFS_VIDEO, 8'h00, {1'b1, 8'(v)});
      if (!v[2] || !v[0]) chk("dark", 18'h00000, {red, green, blue});
      else if (!v[1]) chk("border", bmdl, {red, green, blue});
      chk("valid", {17'h00000, v[2]}, {17'h00000, out_valid});
    end
    repeat (4) @(posedge mclk);
    $display("test video controls done");
    end_sim();
  end
endmodule
